/* logic/sanwp_cmd_top.sv */
// Top: task-file command handling for sanitize and write protection, with an AHB-Lite register slave
//
// Notes on behaviour
// - Opcode 01h, zero parameters: one erase then one random overwrite.
// - Repeat count N-1 with opcode 01h gives exactly N random passes.
// - Opcode 9Eh with 00h/FFh: zeros, ones, then random, each after erase.
// - Opcode 45h: two erase-plus-random passes.
// - Opcode 42h: erase, fill with character, then final erase only.
// - Opcode 49h: one random pass then one character pass.
// - Opcode 02h: one erase then overwrite with character.
// - Opcode B9h: random, character, complement, each after erase.
// - Opcode 9Eh: character, complement, random, each after erase.
// - Opcode 8Eh with 55h/AAh: 55h, AAh, then final erase only.
// - After sanitize: ready shown, but no further command is processed.
// - Protection from jumper pin or software, switchable at run time.
// - Protected: media writes other than sanitize aborted with error status.
// - Request Sense right after protect abort returns error code 27h.
// - Command 82h: count in Features, opcode Sector Count, fills in Number/CylLow.
// - Opcode bits 7:6 give one, two or three passes; 11 reserved.
// - Bit pairs 1:0, 3:2, 5:4 pick pass one, two, three operation.
// - First pass runs count+1 times.
`timescale 1ns/1ps
module sanwp_cmd_top (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic [31:0]              hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    // Write-protect jumper pin
    input  wire logic                wpJumper,
    // Media engine
    output logic                     passReq,
    output sanwp_pkg::sanwp_pass_t   passCmd,
    input  wire logic                passDone,
    // Host status
    output logic                     devBusy,
    output logic                     devReady,
    output logic                     devError,
    output logic [7:0]               errorReg,
    output logic                     cmdDone,
    output logic                     writeExec
);
    import sanwp_pkg::*;

    // Pin synchroniser
    logic [2:0] jmpSync;
    logic       jumperOn;
    // Registers
    sanwp_cmd_t cmdReg;
    logic       swProtect;
    logic       sanitized;
    logic       lastProtAbort;
    // Bus address phase capture
    logic       dataPhase;
    logic       dataWrite;
    logic [7:0] dataAddr;
    // Command strobe
    logic       cmdGo;
    // Sequencer
    logic       seqStart;
    logic       seqBusy;
    logic       seqDone;
    logic [1:0] seqIdx;
    logic       protActive;

    // Three-stage pin sync; change taken when stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            jmpSync  <= 3'b000;
            jumperOn <= 1'b0;
        end else begin
            jmpSync <= {jmpSync[1:0], wpJumper};
            if (jmpSync[1] == jmpSync[2]) begin
                jumperOn <= jmpSync[2];
            end
        end
    end

    assign protActive = jumperOn | swProtect;

    // Bus address phase
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dataPhase <= 1'b0;
            dataWrite <= 1'b0;
            dataAddr  <= 8'h00;
        end else if (hready) begin
            dataPhase <= hsel & htrans[1];
            dataWrite <= hwrite;
            dataAddr  <= haddr[7:0];
        end
    end

    // Zero-wait, always OKAY
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Task-file writes; command register write launches the command
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmdReg    <= '0;
            swProtect <= 1'b0;
            cmdGo     <= 1'b0;
        end else begin
            cmdGo <= 1'b0;
            if (dataPhase && dataWrite) begin
                unique case (dataAddr)
                    SANWP_ADDR_PARAM: begin
                        cmdReg.features <= hwdata[7:0];
                        cmdReg.count    <= hwdata[15:8];
                        cmdReg.number   <= hwdata[23:16];
                        cmdReg.cylLow   <= hwdata[31:24];
                    end
                    SANWP_ADDR_CMD: begin
                        // Dropped while busy, during launch or after wipe; no acceptance shown
                        if (!seqBusy && !seqStart && !seqDone && !sanitized &&
                            !(cmdGo && cmdReg.code == SANWP_CMD_SANITIZE)) begin
                            cmdReg.code        <= hwdata[7:0];
                            cmdReg.writesMedia <= hwdata[8];
                            cmdGo              <= 1'b1;
                        end
                    end
                    SANWP_ADDR_CTRL: swProtect <= hwdata[0];
                    default: ;
                endcase
            end
        end
    end

    // Command execution
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            seqStart      <= 1'b0;
            devError      <= 1'b0;
            errorReg      <= 8'h00;
            cmdDone       <= 1'b0;
            writeExec     <= 1'b0;
            lastProtAbort <= 1'b0;
            sanitized     <= 1'b0;
        end else begin
            seqStart  <= 1'b0;
            cmdDone   <= 1'b0;
            writeExec <= 1'b0;
            if (seqDone) begin
                sanitized <= 1'b1;
                cmdDone   <= 1'b1;
                // Status cleared with the completion, not at launch
                devError  <= 1'b0;
                errorReg  <= 8'h00;
            end
            if (cmdGo) begin
                if (cmdReg.code == SANWP_CMD_SANITIZE) begin
                    // Sanitize itself wipes media, even under protection
                    seqStart      <= 1'b1;
                    lastProtAbort <= 1'b0;
                end else if (cmdReg.code == SANWP_CMD_REQSENSE) begin
                    cmdDone       <= 1'b1;
                    devError      <= 1'b0;
                    errorReg      <= lastProtAbort ? SANWP_ERR_WPROT : 8'h00;
                    lastProtAbort <= 1'b0;
                end else if (cmdReg.writesMedia && protActive) begin
                    cmdDone       <= 1'b1;
                    devError      <= 1'b1;
                    errorReg      <= SANWP_ERR_ABORT;
                    lastProtAbort <= 1'b1;
                end else begin
                    cmdDone       <= 1'b1;
                    writeExec     <= cmdReg.writesMedia;
                    devError      <= 1'b0;
                    errorReg      <= 8'h00;
                    lastProtAbort <= 1'b0;
                end
            end
        end
    end

    sanwp_pass_seq u_seq (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .start       (seqStart),
        .opcode      (cmdReg.count),
        .repeatCount (cmdReg.features),
        .fill1       (cmdReg.number),
        .fill2       (cmdReg.cylLow),
        .passReq     (passReq),
        .passCmd     (passCmd),
        .passDone    (passDone),
        .busy        (seqBusy),
        .done        (seqDone),
        .passIdx     (seqIdx)
    );

    // Host status; busy covers the launch cycle too
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            devBusy  <= 1'b0;
            devReady <= 1'b0;
        end else begin
            devBusy  <= seqBusy | seqStart;
            devReady <= ~(seqBusy | seqStart);
        end
    end

    // Read data
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hrdata <= SANWP_RST_WORD;
        end else if (hsel && htrans[1] && !hwrite && hready) begin
            unique case (haddr[7:0])
                SANWP_ADDR_CMD:    hrdata <= {23'h0, cmdReg.writesMedia, cmdReg.code};
                SANWP_ADDR_PARAM:  hrdata <= {cmdReg.cylLow, cmdReg.number, cmdReg.count, cmdReg.features};
                SANWP_ADDR_STATUS: hrdata <= {16'h0, errorReg, 2'b00, sanitized, protActive,
                                              jumperOn, devError, ~seqBusy, seqBusy};
                SANWP_ADDR_CTRL:   hrdata <= {31'h0, swProtect};
                SANWP_ADDR_PASS:   hrdata <= {30'h0, seqIdx};
                default:           hrdata <= SANWP_RST_WORD;
            endcase
        end
    end
endmodule

/* logic/sanwp_pkg.sv */
// Package: constants and carrier types for the sanitize / write-protect command block
package sanwp_pkg;
    // Command and error codes
    localparam logic [7:0] SANWP_CMD_SANITIZE    = 8'h82;
    localparam logic [7:0] SANWP_CMD_REQSENSE    = 8'h03;
    localparam logic [7:0] SANWP_ERR_WPROT       = 8'h27;
    localparam logic [7:0] SANWP_ERR_ABORT       = 8'h04;
    // Opcode field positions
    localparam int SANWP_NPASS_LSB = 6;
    localparam int SANWP_OPW       = 2;
    // Pass operations
    typedef enum logic [1:0] {
        SANWP_OP_ERASE = 2'b00,
        SANWP_OP_RAND  = 2'b01,
        SANWP_OP_FILL1 = 2'b10,
        SANWP_OP_FILL2 = 2'b11
    } sanwp_op_t;
    localparam logic [1:0] SANWP_NPASS_RSVD = 2'b11;
    // Register map (byte addresses)
    localparam logic [7:0] SANWP_ADDR_CMD    = 8'h00;
    localparam logic [7:0] SANWP_ADDR_PARAM  = 8'h04;
    localparam logic [7:0] SANWP_ADDR_STATUS = 8'h08;
    localparam logic [7:0] SANWP_ADDR_CTRL   = 8'h0c;
    localparam logic [7:0] SANWP_ADDR_PASS   = 8'h10;
    // Reset values
    localparam logic [31:0] SANWP_RST_WORD = 32'h0000_0000;
    // Media pass handshake
    typedef struct packed {
        logic      erase;
        logic      write;
        logic      random;
        logic [7:0] fill;
    } sanwp_pass_t;
    // Task-file command
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] features;
        logic [7:0] count;
        logic [7:0] number;
        logic [7:0] cylLow;
        logic       writesMedia;
    } sanwp_cmd_t;
endpackage

/* logic/sanwp_pass_seq.sv */
// Pass sequencer: turns a sanitize opcode into the ordered erase / overwrite passes
`timescale 1ns/1ps
module sanwp_pass_seq (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst,
    // Start
    input  wire logic                start,
    input  wire logic [7:0]          opcode,
    input  wire logic [7:0]          repeatCount,
    input  wire logic [7:0]          fill1,
    input  wire logic [7:0]          fill2,
    // Media engine
    output logic                     passReq,
    output sanwp_pkg::sanwp_pass_t   passCmd,
    input  wire logic                passDone,
    // Status
    output logic                     busy,
    output logic                     done,
    output logic [1:0]               passIdx
);
    import sanwp_pkg::*;

    typedef enum logic [1:0] {
        SANWP_S_IDLE  = 2'b00,
        SANWP_S_ISSUE = 2'b01,
        SANWP_S_WAIT  = 2'b10
    } sanwp_seq_t;

    sanwp_seq_t state;
    logic [1:0] lastIdx;
    logic [8:0] repLeft;
    logic [7:0] opReg;
    logic [7:0] f1Reg;
    logic [7:0] f2Reg;
    sanwp_op_t  curOp;

    assign curOp = sanwp_op_t'(opReg[passIdx*SANWP_OPW +: SANWP_OPW]);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state   <= SANWP_S_IDLE;
            passIdx <= 2'd0;
            lastIdx <= 2'd0;
            repLeft <= 9'd0;
            opReg   <= 8'h00;
            f1Reg   <= 8'h00;
            f2Reg   <= 8'h00;
            passReq <= 1'b0;
            passCmd <= '0;
            busy    <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state)
                SANWP_S_IDLE: begin
                    if (start) begin
                        opReg   <= opcode;
                        f1Reg   <= fill1;
                        f2Reg   <= fill2;
                        passIdx <= 2'd0;
                        // Reserved count treated as three passes; firmware is wiped anyway
                        lastIdx <= (opcode[7:6] == SANWP_NPASS_RSVD) ? 2'd2 : opcode[7:6];
                        repLeft <= {1'b0, repeatCount};
                        busy    <= 1'b1;
                        state   <= SANWP_S_ISSUE;
                    end
                end
                SANWP_S_ISSUE: begin
                    // Every pass erases first, then writes per its op code
                    passCmd.erase  <= 1'b1;
                    passCmd.write  <= (curOp != SANWP_OP_ERASE);
                    passCmd.random <= (curOp == SANWP_OP_RAND);
                    passCmd.fill   <= (curOp == SANWP_OP_FILL2) ? f2Reg :
                                      (curOp == SANWP_OP_FILL1) ? f1Reg : 8'h00;
                    passReq <= 1'b1;
                    state   <= SANWP_S_WAIT;
                end
                SANWP_S_WAIT: begin
                    passReq <= 1'b0;
                    if (passDone && !passReq) begin
                        if (passIdx == 2'd0 && repLeft != 9'd0) begin
                            repLeft <= repLeft - 9'd1;
                            state   <= SANWP_S_ISSUE;
                        end else if (passIdx != lastIdx) begin
                            passIdx <= passIdx + 2'd1;
                            state   <= SANWP_S_ISSUE;
                        end else begin
                            busy  <= 1'b0;
                            done  <= 1'b1;
                            state <= SANWP_S_IDLE;
                        end
                    end
                end
                default: state <= SANWP_S_IDLE;
            endcase
        end
    end
endmodule

/* sim/sanwp_cmd_props.sv */
// Checker: port-level properties of the sanitize and write-protect block
`timescale 1ns/1ps
module sanwp_cmd_props (
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  rst,
    // Observed outputs
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire logic                  passReq,
    input wire sanwp_pkg::sanwp_pass_t passCmd,
    input wire logic                  devBusy,
    input wire logic                  devReady,
    input wire logic                  devError,
    input wire logic [7:0]            errorReg,
    input wire logic                  cmdDone,
    input wire logic                  writeExec
);
    import sanwp_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
    pass_pulse_a: assert property (passReq |=> !passReq) else $error("pass request too long");
    pass_busy_a: assert property (passReq |-> devBusy && !cmdDone) else $error("pass outside busy");
    pass_erase_a: assert property (passReq |-> passCmd.erase) else $error("pass without erase");
    cmd_hold_a: assert property ($changed(passCmd) |-> passReq) else $error("pass command moved");
    ready_busy_a: assert property (!$past(rst) |-> devReady == !devBusy) else $error("ready not busy");
    busy_end_a: assert property ($fell(devBusy) |-> cmdDone) else $error("busy ended early");
    done_pulse_a: assert property (cmdDone |=> !cmdDone) else $error("done too long");
    exec_ok_a: assert property (writeExec |-> cmdDone && !devError) else $error("write let through");
    abort_code_a: assert property (cmdDone && devError |-> errorReg == SANWP_ERR_ABORT)
        else $error("abort code wrong");
    code_moves_a: assert property ($changed(errorReg) |-> cmdDone) else $error("error code off done");
endmodule

bind sanwp_cmd_top sanwp_cmd_props sanwp_cmd_props_i (.sys_clk(sys_clk), .rst(rst), .hreadyout(hreadyout),
    .hresp(hresp), .passReq(passReq), .passCmd(passCmd), .devBusy(devBusy), .devReady(devReady),
    .devError(devError), .errorReg(errorReg), .cmdDone(cmdDone), .writeExec(writeExec));

/* sim/sanwp_media_model.sv */
// Partner model: media engine answering each pass request after a short or long delay
`timescale 1ns/1ps
module sanwp_media_model (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Pass handshake
    input  wire logic passReq,
    input  wire logic slow,
    output logic      passDone
);
    logic [3:0] waitCnt;
    logic       active;
    // Done never in the request cycle, the sequencer ignores it there
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            active   <= 1'b0;
            waitCnt  <= 4'h0;
            passDone <= 1'b0;
        end else if (passReq) begin
            active   <= 1'b1;
            waitCnt  <= slow ? 4'h9 : 4'h1;
            passDone <= 1'b0;
        end else if (active && waitCnt == 4'h0) begin
            active   <= 1'b0;
            passDone <= 1'b1;
        end else begin
            waitCnt  <= waitCnt - 4'h1;
            passDone <= 1'b0;
        end
    end
endmodule

/* sim/testbench.sv */
// Testbench: sanitize pass sequences, busy lockout and write protection
`timescale 1ns/1ps
module testbench;
    import sanwp_pkg::*;
    typedef struct packed {
        logic [7:0] op, cnt, f1, f2;
        logic [2:0] n;
        logic [7:0] seq;
    } sanwp_row_t;
    logic        sys_clk, rst, hsel, hwrite, hready, hreadyout, hresp, wpJumper, passReq, passDone, slowMode;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic        devBusy, devReady, devError, cmdDone, writeExec;
    logic [7:0]  errorReg;
    logic [8:0]  gotErr;
    sanwp_pass_t passCmd;
    sanwp_pass_t q[$];
    int          bad_count, checks, doneCnt, execCnt;
    sanwp_row_t  rows [13] = '{
        '{8'h01, 8'h00, 8'h00, 8'h00, 3'h1, 8'h01},
        '{8'h01, 8'h02, 8'h00, 8'h00, 3'h3, 8'h15},
        '{8'h9e, 8'h00, 8'h00, 8'hff, 3'h3, 8'h1e},
        '{8'h45, 8'h00, 8'h00, 8'h00, 3'h2, 8'h05},
        '{8'h42, 8'h00, 8'h5a, 8'h00, 3'h2, 8'h02},
        '{8'h49, 8'h00, 8'h33, 8'h00, 3'h2, 8'h09},
        '{8'h02, 8'h00, 8'h77, 8'h00, 3'h1, 8'h02},
        '{8'hb9, 8'h00, 8'h3c, 8'hc3, 3'h3, 8'h39},
        '{8'h9e, 8'h00, 8'ha5, 8'h5a, 3'h3, 8'h1e},
        '{8'h8e, 8'h00, 8'h55, 8'haa, 3'h3, 8'h0e},
        '{8'h00, 8'h00, 8'h00, 8'h00, 3'h1, 8'h00},
        '{8'h42, 8'h01, 8'h5a, 8'h00, 3'h3, 8'h0a},
        '{8'hc1, 8'h00, 8'h00, 8'h00, 3'h3, 8'h01}
    };
    assign hready = hreadyout;
    sanwp_cmd_top sanwp_cmd_top_i (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .wpJumper(wpJumper), .passReq(passReq), .passCmd(passCmd), .passDone(passDone),
        .devBusy(devBusy), .devReady(devReady), .devError(devError), .errorReg(errorReg), .cmdDone(cmdDone),
        .writeExec(writeExec));
    sanwp_media_model sanwp_media_model_i (.sys_clk(sys_clk), .rst(rst), .passReq(passReq), .slow(slowMode),
        .passDone(passDone));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Registered outputs seen one edge late, consistently
    always @(posedge sys_clk) begin
        if (passReq === 1'b1) q.push_back(passCmd);
        if (cmdDone === 1'b1) begin
            doneCnt++;
            gotErr = {devError, errorReg};
        end
        if (writeExec === 1'b1) execCnt++;
    end
    task automatic final_report();
        if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Holds address until hready, then data until hready again
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(what, exp, r);
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic cmd(input logic [8:0] c, input logic [31:0] expDone, input logic [31:0] expErr,
                       input logic [31:0] expExec);
        int d0, e0;
        logic [31:0] x;
        d0 = doneCnt;
        e0 = execCnt;
        ahb(1'b1, SANWP_ADDR_CMD, {23'h0, c}, x);
        repeat (6) @(posedge sys_clk);
        chk("cmdDone", expDone, 32'(doneCnt - d0));
        if (expDone != 32'h0) chk("error", expErr, {23'h0, gotErr});
        chk("writeExec", expExec, 32'(execCnt - e0));
    endtask
    task automatic sanitize(input sanwp_row_t r);
        int i, d0;
        logic [31:0] x;
        do_reset();
        q.delete();
        ahb(1'b1, SANWP_ADDR_PARAM, {r.f2, r.f1, r.op, r.cnt}, x);
        d0 = doneCnt;
        ahb(1'b1, SANWP_ADDR_CMD, {24'h0, SANWP_CMD_SANITIZE}, x);
        for (i = 0; i < 2000 && doneCnt == d0; i++) @(posedge sys_clk);
    endtask
    initial begin
        int k, i;
        logic [1:0] op;
        logic [7:0] f;
        logic [31:0] x;
        {rst, hsel, hwrite, wpJumper, slowMode} = 5'h10;
        {haddr, hwdata, htrans} = '0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd("status", SANWP_ADDR_STATUS, 32'h2);
        rd("ctrl", SANWP_ADDR_CTRL, 32'h0);
        rd("unmapped", 8'h40, 32'h0);
        for (k = 0; k < 13; k++) begin
            slowMode <= k[0];
            sanitize(rows[k]);
            chk("passes", {29'h0, rows[k].n}, 32'(q.size()));
            for (i = 0; i < rows[k].n; i++) begin
                op = rows[k].seq[2*i +: 2];
                // Erase-only and random passes carry no fill character
                f = op == 2'h2 ? rows[k].f1 : op == 2'h3 ? rows[k].f2 : 8'h00;
                chk("pass", {21'h0, 1'b1, op != 2'h0, op == 2'h1, f}, {21'h0, q[i]});
            end
        end
        slowMode <= 1'b1;
        do_reset();
        ahb(1'b1, SANWP_ADDR_PARAM, 32'h0000_0103, x);
        ahb(1'b1, SANWP_ADDR_CMD, {24'h0, SANWP_CMD_SANITIZE}, x);
        // Status is taken at the address phase; busy rises two edges after the command
        repeat (2) @(posedge sys_clk);
        rd("busy", SANWP_ADDR_STATUS, 32'h1);
        cmd(9'h130, 32'h0, 32'h0, 32'h0);
        for (i = 0; i < 500 && devBusy !== 1'b0; i++) @(posedge sys_clk);
        rd("sanitized", SANWP_ADDR_STATUS, 32'h22);
        cmd(9'h020, 32'h0, 32'h0, 32'h0);
        do_reset();
        ahb(1'b1, SANWP_ADDR_CTRL, 32'h1, x);
        cmd(9'h130, 32'h1, 32'h104, 32'h0);
        cmd({1'b0, SANWP_CMD_REQSENSE}, 32'h1, 32'h027, 32'h0);
        cmd(9'h020, 32'h1, 32'h0, 32'h0);
        ahb(1'b1, SANWP_ADDR_CTRL, 32'h0, x);
        cmd(9'h130, 32'h1, 32'h0, 32'h1);
        wpJumper <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rd("jumper", SANWP_ADDR_STATUS, 32'h1a);
        cmd(9'h130, 32'h1, 32'h104, 32'h0);
        final_report();
    end
    initial begin
        repeat (40000) @(posedge sys_clk);
        bad_count++;
        final_report();
    end
endmodule
